// file: verilog/tpm_consts.svh
// Purpose: Constants for the tunneled packet to PLP mapper
// Assumes: Included by bare name from the entry match and mapper design files
// Notes:   Offsets, sizes, reset values and codes
`ifndef TPM_CONSTS_SVH
`define TPM_CONSTS_SVH

`define TPM_N_TUN        4
`define TPM_N_ENT        8
`define TPM_TUN_W        2
`define TPM_ENT_W        3
`define TPM_PLP_W        16
`define TPM_IP_W         32
`define TPM_PORT_W       16
`define TPM_FALLBACK_PLP 16'h0000
`define TPM_SEC_ADDR     32'h0000_0000
`define TPM_IGMP_NONE    2'h0
`define TPM_IGMP_V2      2'h2
`define TPM_IGMP_V3      2'h3

`endif

// file: verilog/tpm_pkg.sv
// Purpose: Types for the tunneled packet to PLP mapper
// Assumes: Nothing beyond the constants header
// Notes:   Configuration write kinds
`default_nettype none

package tpm_pkg;

    // Kind of a control-plane configuration write
    typedef enum logic [1:0] {
        TPM_CFG_TUNNEL,
        TPM_CFG_ENTRY,
        TPM_CFG_BACKUP,
        TPM_CFG_CLEAR
    } tpm_cfg_kind_type;

endpackage : tpm_pkg

`default_nettype wire

// file: verilog/tpm_entry_match.sv
// Purpose: Compare one stream entry against a header address and port
// Assumes: Purely combinational, same clock as the caller
// Notes:   Hit only when the entry is valid
`include "tpm_consts.svh"
`default_nettype none

module tpm_entry_match
    import tpm_pkg::*;
(
    input  wire logic                     ent_valid,
    input  wire logic [`TPM_IP_W-1:0]     ent_ip,
    input  wire logic [`TPM_PORT_W-1:0]   ent_port,
    input  wire logic [`TPM_IP_W-1:0]     hdr_ip,
    input  wire logic [`TPM_PORT_W-1:0]   hdr_port,
    output logic                          hit
);

    // Address and port must both agree
    assign hit = ent_valid && (ent_ip == hdr_ip) && (ent_port == hdr_port);

endmodule : tpm_entry_match

`default_nettype wire

// file: verilog/tpm_mapper.sv
// Purpose: Route tunneled packets to PLPs from a loaded mapping table
// Assumes: Parser and control plane share mclk; one packet per cycle max
// Notes:   One cycle from pkt_valid to a result pulse
//
// Behaviour
// R1: Matching inner address and port routes packet to that entry's PLP.
// R2: Unmatched packets go to the tunnel's fallback PLP.
// R3: Without a configured fallback, PLP zero is the fallback.
// R4: Tunnel with no entries sends every packet to its fallback.
// R5: One combination maps to one PLP; each packet reaches one PLP only.
// R6: Several tunnels, each keyed by destination address and port, own entries.
// R7: IGMP version accepts 2 or 3; absent means no membership signalling (code still issues version 3 backup joins for such a tunnel).
// R8: Configurer supplies source address when IGMP 3 with source-specific multicast.
// R9: Primary lost: join backup source using IGMP version 3.
// R10: Mapping loads only through the separate configuration port.
// R11: Configured tunnel source address restricts accepted source; else any.
// R12: Inner destination address is the header's first 32-bit field.
// R13: Inner port is the following 16-bit header field.
// R14: All-zero address marks a security packet, consumed, never mapped.
// R15: Each result gives the 16-bit PLP and entry-or-fallback origin.
`include "tpm_consts.svh"
`default_nettype none

module tpm_mapper
    import tpm_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    // Control-plane configuration port
    input  wire logic                     cfg_wr,
    input  wire tpm_cfg_kind_type         cfg_kind,
    input  wire logic [`TPM_TUN_W-1:0]    cfg_tun,
    input  wire logic [`TPM_ENT_W-1:0]    cfg_ent,
    input  wire logic                     cfg_enable,
    input  wire logic [`TPM_IP_W-1:0]     cfg_ip,
    input  wire logic [`TPM_PORT_W-1:0]   cfg_port,
    input  wire logic                     cfg_src_en,
    input  wire logic [`TPM_IP_W-1:0]     cfg_src_ip,
    input  wire logic [1:0]               cfg_igmp,
    input  wire logic                     cfg_dflt_en,
    input  wire logic [`TPM_PLP_W-1:0]    cfg_plp,
    output logic                          cfg_err,
    // Packet header from the tunnel parser
    input  wire logic                     pkt_valid,
    input  wire logic [`TPM_IP_W-1:0]     pkt_tun_ip,
    input  wire logic [`TPM_PORT_W-1:0]   pkt_tun_port,
    input  wire logic [`TPM_IP_W-1:0]     pkt_src_ip,
    input  wire logic [`TPM_IP_W-1:0]     hdr_word0,
    input  wire logic [`TPM_PORT_W-1:0]   hdr_port_field,
    // Routing result
    output logic                          route_valid,
    output logic [`TPM_PLP_W-1:0]         route_plp,
    output logic                          route_from_entry,
    output logic [`TPM_TUN_W-1:0]         route_tun,
    output logic                          sec_valid,
    output logic                          drop_valid,
    // Membership signalling
    input  wire logic [`TPM_N_TUN-1:0]    primary_lost,
    output logic [`TPM_N_TUN*2-1:0]       tun_igmp,
    output logic                          join_valid,
    output logic [`TPM_TUN_W-1:0]         join_tun,
    output logic [`TPM_IP_W-1:0]          join_src_ip,
    output logic [1:0]                    join_igmp
);

    ////////////////////////////////////////////////////////////////////////
    // Configuration storage
    logic [`TPM_N_TUN-1:0]                tun_valid_ff;
    logic [`TPM_IP_W-1:0]                 tun_ip_ff    [`TPM_N_TUN];
    logic [`TPM_PORT_W-1:0]               tun_port_ff  [`TPM_N_TUN];
    logic [`TPM_N_TUN-1:0]                tun_src_en_ff;
    logic [`TPM_IP_W-1:0]                 tun_src_ff   [`TPM_N_TUN];
    logic [1:0]                           tun_igmp_ff  [`TPM_N_TUN];
    logic [`TPM_PLP_W-1:0]                tun_dflt_ff  [`TPM_N_TUN];
    logic [`TPM_N_TUN-1:0]                bk_valid_ff;
    logic [`TPM_IP_W-1:0]                 bk_src_ff    [`TPM_N_TUN];
    logic [`TPM_N_ENT-1:0]                ent_valid_ff [`TPM_N_TUN];
    logic [`TPM_IP_W-1:0]                 ent_ip_ff    [`TPM_N_TUN][`TPM_N_ENT];
    logic [`TPM_PORT_W-1:0]               ent_port_ff  [`TPM_N_TUN][`TPM_N_ENT];
    logic [`TPM_PLP_W-1:0]                ent_plp_ff   [`TPM_N_TUN][`TPM_N_ENT];
    logic                                 igmp_ok;

    // R7: Version check
    assign igmp_ok = (cfg_igmp == `TPM_IGMP_NONE) || (cfg_igmp == `TPM_IGMP_V2)
                     || (cfg_igmp == `TPM_IGMP_V3);

    // R10: Control-plane writes only
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tun_valid_ff  <= '0;
            tun_src_en_ff <= '0;
            bk_valid_ff   <= '0;
            for (int t = 0; t < `TPM_N_TUN; t++) begin
                ent_valid_ff[t] <= '0;
                tun_igmp_ff[t]  <= `TPM_IGMP_NONE;
                tun_dflt_ff[t]  <= `TPM_FALLBACK_PLP;
            end
        end else if (cfg_wr) begin
            case (cfg_kind)
                // R6: Tunnel key and options
                TPM_CFG_TUNNEL: begin
                    if (igmp_ok) begin
                        tun_valid_ff[cfg_tun]  <= cfg_enable;
                        tun_src_en_ff[cfg_tun] <= cfg_src_en;
                        tun_igmp_ff[cfg_tun]   <= cfg_igmp;
                        // R3: Zero when absent
                        tun_dflt_ff[cfg_tun]   <= cfg_dflt_en ? cfg_plp : `TPM_FALLBACK_PLP;
                    end
                end
                TPM_CFG_ENTRY: begin
                    ent_valid_ff[cfg_tun][cfg_ent] <= cfg_enable;
                end
                TPM_CFG_BACKUP: begin
                    bk_valid_ff[cfg_tun] <= cfg_enable;
                end
                TPM_CFG_CLEAR: begin
                    tun_valid_ff[cfg_tun]  <= 1'b0;
                    tun_src_en_ff[cfg_tun] <= 1'b0;
                    bk_valid_ff[cfg_tun]   <= 1'b0;
                    ent_valid_ff[cfg_tun]  <= '0;
                    tun_igmp_ff[cfg_tun]   <= `TPM_IGMP_NONE;
                    tun_dflt_ff[cfg_tun]   <= `TPM_FALLBACK_PLP;
                end
                default: begin
                    tun_valid_ff[cfg_tun] <= tun_valid_ff[cfg_tun];
                end
            endcase
        end
    end

    // Table data, qualified by the valid bits above
    always_ff @(posedge mclk) begin
        if (cfg_wr && cfg_kind == TPM_CFG_TUNNEL && igmp_ok) begin
            tun_ip_ff[cfg_tun]   <= cfg_ip;
            tun_port_ff[cfg_tun] <= cfg_port;
            tun_src_ff[cfg_tun]  <= cfg_src_ip;
        end
        if (cfg_wr && cfg_kind == TPM_CFG_ENTRY) begin
            ent_ip_ff[cfg_tun][cfg_ent]   <= cfg_ip;
            ent_port_ff[cfg_tun][cfg_ent] <= cfg_port;
            ent_plp_ff[cfg_tun][cfg_ent]  <= cfg_plp;
        end
        if (cfg_wr && cfg_kind == TPM_CFG_BACKUP) begin
            bk_src_ff[cfg_tun] <= cfg_src_ip;
        end
    end

    // Rejected tunnel write flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_err <= 1'b0;
        end else begin
            cfg_err <= cfg_wr && (cfg_kind == TPM_CFG_TUNNEL) && !igmp_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lookup
    logic                                 tun_hit;
    logic [`TPM_TUN_W-1:0]                tun_idx;
    logic                                 src_ok;
    logic [`TPM_N_ENT-1:0]                ent_hit;
    logic                                 any_hit;
    logic [`TPM_ENT_W-1:0]                hit_idx;

    // R6: Find tunnel by destination key
    always_comb begin
        tun_hit = 1'b0;
        tun_idx = '0;
        for (int t = 0; t < `TPM_N_TUN; t++) begin
            if (!tun_hit && tun_valid_ff[t] && tun_ip_ff[t] == pkt_tun_ip
                && tun_port_ff[t] == pkt_tun_port) begin
                tun_hit = 1'b1;
                tun_idx = `TPM_TUN_W'(t);
            end
        end
    end

    // R11: Source restriction
    assign src_ok = !tun_src_en_ff[tun_idx] || (tun_src_ff[tun_idx] == pkt_src_ip);

    // R12: Address from first field, R13: port follows
    for (genvar e = 0; e < `TPM_N_ENT; e++) begin : g_ent
        tpm_entry_match u_match (
            .ent_valid (ent_valid_ff[tun_idx][e]),
            .ent_ip    (ent_ip_ff[tun_idx][e]),
            .ent_port  (ent_port_ff[tun_idx][e]),
            .hdr_ip    (hdr_word0),
            .hdr_port  (hdr_port_field),
            .hit       (ent_hit[e])
        );
    end

    // R5: Lowest hit wins, single PLP
    always_comb begin
        any_hit = 1'b0;
        hit_idx = '0;
        for (int e = 0; e < `TPM_N_ENT; e++) begin
            if (!any_hit && ent_hit[e]) begin
                any_hit = 1'b1;
                hit_idx = `TPM_ENT_W'(e);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            route_valid      <= 1'b0;
            route_plp        <= `TPM_FALLBACK_PLP;
            route_from_entry <= 1'b0;
            route_tun        <= '0;
            sec_valid        <= 1'b0;
            drop_valid       <= 1'b0;
        end else begin
            // R14: Security packet consumed locally
            sec_valid   <= pkt_valid && tun_hit && src_ok && hdr_word0 == `TPM_SEC_ADDR;
            drop_valid  <= pkt_valid && !(tun_hit && src_ok);
            route_valid <= pkt_valid && tun_hit && src_ok && hdr_word0 != `TPM_SEC_ADDR;
            if (pkt_valid) begin
                route_tun <= tun_idx;
                // R15: PLP and origin
                route_from_entry <= any_hit;
                // R1: Entry PLP, R2: R4: fallback otherwise
                route_plp <= any_hit ? ent_plp_ff[tun_idx][hit_idx] : tun_dflt_ff[tun_idx];
            end
        end
    end

    // R7: Per-tunnel IGMP version out, zero means none
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tun_igmp <= '0;
        end else begin
            for (int t = 0; t < `TPM_N_TUN; t++) begin
                tun_igmp[t*2 +: 2] <= tun_valid_ff[t] ? tun_igmp_ff[t] : `TPM_IGMP_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Backup join requests
    logic [`TPM_N_TUN-1:0]                lost_s1_ff;
    logic [`TPM_N_TUN-1:0]                lost_s2_ff;
    logic [`TPM_N_TUN-1:0]                lost_prev_ff;
    logic [`TPM_N_TUN-1:0]                pend_ff;
    logic [`TPM_N_TUN-1:0]                issue;
    logic                                 issue_any;
    logic [`TPM_TUN_W-1:0]                issue_idx;

    // Two-stage sync of loss indications
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lost_s1_ff   <= '0;
            lost_s2_ff   <= '0;
            lost_prev_ff <= '0;
        end else begin
            lost_s1_ff   <= primary_lost;
            lost_s2_ff   <= lost_s1_ff;
            lost_prev_ff <= lost_s2_ff;
        end
    end

    // Lowest pending tunnel is served first
    always_comb begin
        issue_any = 1'b0;
        issue_idx = '0;
        issue     = '0;
        for (int t = 0; t < `TPM_N_TUN; t++) begin
            if (!issue_any && pend_ff[t]) begin
                issue_any = 1'b1;
                issue_idx = `TPM_TUN_W'(t);
                issue[t]  = 1'b1;
            end
        end
    end

    // R9: New loss queues a join; set beats clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= '0;
        end else begin
            pend_ff <= (pend_ff & ~issue)
                       | (lost_s2_ff & ~lost_prev_ff & bk_valid_ff & tun_valid_ff);
        end
    end

    // R9: Join via IGMP version 3
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            join_valid  <= 1'b0;
            join_tun    <= '0;
            join_src_ip <= '0;
            join_igmp   <= `TPM_IGMP_NONE;
        end else begin
            join_valid <= issue_any;
            if (issue_any) begin
                join_tun    <= issue_idx;
                join_src_ip <= bk_src_ff[issue_idx];
                join_igmp   <= `TPM_IGMP_V3;
            end
        end
    end

endmodule : tpm_mapper

`default_nettype wire

// file: test/tpm_mapper_chk.sv
// Purpose: Port assertions for the mapper
// Assumes: One clock, reset active low
// Notes:   Bound to every mapper instance
`include "tpm_consts.svh"
`default_nettype none

module tpm_mapper_chk
    import tpm_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic                  cfg_wr,
    input wire tpm_cfg_kind_type      cfg_kind,
    input wire logic [1:0]            cfg_igmp,
    input wire logic                  cfg_err,
    input wire logic                  pkt_valid,
    input wire logic [`TPM_IP_W-1:0]  hdr_word0,
    input wire logic                  route_valid,
    input wire logic [`TPM_PLP_W-1:0] route_plp,
    input wire logic                  sec_valid,
    input wire logic                  drop_valid,
    input wire logic                  join_valid,
    input wire logic [1:0]            join_igmp
);
    default clocking
        @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Tunnel write with the refused version
    sequence s_bad_cfg;
        cfg_wr && cfg_kind == TPM_CFG_TUNNEL && cfg_igmp == 2'h1;
    endsequence

    // One answer for each header, none otherwise
    a_one_result: assert property (
        pkt_valid |=> $onehot({route_valid, sec_valid, drop_valid}))
        else $error("not exactly one result");
    a_no_spurious: assert property (
        !pkt_valid |=> !(route_valid || sec_valid || drop_valid))
        else $error("result without header");
    a_sec_cause: assert property (
        sec_valid |-> $past(hdr_word0) == `TPM_SEC_ADDR)
        else $error("security pulse for nonzero address");
    a_route_addr: assert property (
        route_valid |-> $past(hdr_word0) != `TPM_SEC_ADDR)
        else $error("zero address routed");
    a_cfg_refuse: assert property (
        s_bad_cfg |=> cfg_err)
        else $error("bad version accepted");
    a_err_cause: assert property (
        cfg_err |-> $past(cfg_wr && cfg_igmp == 2'h1))
        else $error("error pulse without cause");
    a_join_v3: assert property (
        join_valid |-> join_igmp == `TPM_IGMP_V3)
        else $error("join not version 3");
    a_plp_hold: assert property (
        !pkt_valid |=> $stable(route_plp))
        else $error("plp moved without header");
endmodule : tpm_mapper_chk

bind tpm_mapper tpm_mapper_chk tpm_mapper_chk_inst (.*);

`default_nettype wire

// file: test/tpm_parser_model.sv
// Purpose: Upstream tunnel parser model
// Assumes: Header fields launched on rising edges
// Notes:   Released fields show their inverse
`default_nettype none

module tpm_parser_model (
    input  wire logic  mclk,
    output logic        pkt_valid,
    output logic [31:0] pkt_tun_ip,
    output logic [15:0] pkt_tun_port,
    output logic [31:0] pkt_src_ip,
    output logic [31:0] hdr_word0,
    output logic [15:0] hdr_port_field
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle lines at time zero
    initial begin
        pkt_valid = 1'b0;
        {pkt_tun_ip, pkt_tun_port, pkt_src_ip, hdr_word0, hdr_port_field} = '0;
    end

    task automatic send(input logic [31:0] ti, input logic [15:0] tp,
                        input logic [31:0] si, input logic [31:0] da,
                        input logic [15:0] dp);
        @(posedge mclk);
        pkt_valid <= 1'b1;
        {pkt_tun_ip, pkt_tun_port, pkt_src_ip, hdr_word0, hdr_port_field} <= {ti, tp, si, da, dp};
        @(posedge mclk);
        pkt_valid <= 1'b0;
        {pkt_tun_ip, pkt_tun_port, pkt_src_ip, hdr_word0, hdr_port_field} <= ~{ti, tp, si, da, dp};
    endtask : send
endmodule : tpm_parser_model

`default_nettype wire

// file: test/tpm_mapper_bench.sv
// Purpose: Self-checking bench for the mapper
// Assumes: Config and primary loss driven on rising edges
// Notes:   Parser model supplies headers
`include "tpm_consts.svh"
`default_nettype none

module tpm_mapper_bench
    import tpm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic             mclk, rst_n, cfg_wr, cfg_enable, cfg_src_en, cfg_dflt_en, cfg_err;
    tpm_cfg_kind_type cfg_kind;
    logic [1:0]       cfg_tun, cfg_igmp, route_tun, join_tun, join_igmp;
    logic [2:0]       cfg_ent;
    logic [3:0]       primary_lost;
    logic [7:0]       tun_igmp;
    logic [15:0]      cfg_port, cfg_plp, pkt_tun_port, hdr_port_field, route_plp;
    logic [31:0]      cfg_ip, cfg_src_ip, pkt_tun_ip, pkt_src_ip, hdr_word0, join_src_ip;
    logic             pkt_valid, route_valid, route_from_entry, sec_valid, drop_valid;
    logic             join_valid;
    int               num_errors, tests_run;
    localparam logic [31:0] IN = 32'hefff_0010;
    localparam logic [31:0] SRC = 32'h0a00_0001;

    tpm_mapper tpm_mapper_inst (.*);
    tpm_parser_model tpm_parser_model_inst (.*);

    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare, close, drivers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    task automatic cw(input tpm_cfg_kind_type k, input logic [1:0] t, input logic [2:0] e,
                      input logic [31:0] ip, input logic [15:0] pt, input logic [1:0] ig,
                      input logic df, input logic [15:0] plp, input logic se);
        @(posedge mclk);
        cfg_wr <= 1'b1;
        cfg_kind <= k;
        {cfg_tun, cfg_ent, cfg_ip, cfg_port} <= {t, e, ip, pt};
        {cfg_igmp, cfg_dflt_en, cfg_plp, cfg_src_en} <= {ig, df, plp, se};
        @(posedge mclk);
        cfg_wr <= 1'b0;
        #1;
    endtask : cw

    // Send a header; kind is {route, sec, drop}
    task automatic pk(input logic [31:0] ti, input logic [31:0] si, input logic [31:0] da,
                      input logic [15:0] dp, input logic [2:0] k, input logic [15:0] plp,
                      input logic ent);
        tpm_parser_model_inst.send(ti, 16'h1388, si, da, dp);
        #1;
        chk({route_valid, sec_valid, drop_valid}, k);
        if (k == 3'h4) begin
            chk(route_plp, plp);
            chk(route_from_entry, ent);
        end
    endtask : pk

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic sc_match;
        cw(TPM_CFG_TUNNEL, 2'h0, 3'h0, 32'he000_0001, 16'h1388, 2'h2, 1'b1, 16'h0005, 1'b0);
        cw(TPM_CFG_ENTRY, 2'h0, 3'h2, IN, 16'h0fa0, 2'h0, 1'b0, 16'h0011, 1'b0);
        cw(TPM_CFG_ENTRY, 2'h0, 3'h5, IN, 16'h0fa1, 2'h0, 1'b0, 16'h0022, 1'b0);
        pk(32'he000_0001, SRC, IN, 16'h0fa0, 3'h4, 16'h0011, 1'b1);
        pk(32'he000_0001, SRC, IN, 16'h0fa1, 3'h4, 16'h0022, 1'b1);
        pk(32'he000_0001, SRC, IN + 1, 16'h0fa0, 3'h4, 16'h0005, 1'b0);
        pk(32'he000_0001, SRC, 32'h0, 16'h0fa0, 3'h2, 16'h0, 1'b0);
        chk(tun_igmp[1:0], 2'h2);
        chk(route_tun, 2'h0);
    endtask : sc_match

    task automatic sc_fallback;
        cw(TPM_CFG_TUNNEL, 2'h1, 3'h0, 32'he000_0002, 16'h1388, 2'h0, 1'b0, 16'h0007, 1'b0);
        pk(32'he000_0002, SRC, IN, 16'h0fa0, 3'h4, 16'h0000, 1'b0);
        chk(route_tun, 2'h1);
        chk(tun_igmp[3:2], 2'h0);
        cw(TPM_CFG_TUNNEL, 2'h3, 3'h0, 32'he000_0004, 16'h1388, 2'h1, 1'b1, 16'h0003, 1'b0);
        chk(cfg_err, 1'b1);
        pk(32'he000_0004, SRC, IN, 16'h0fa0, 3'h1, 16'h0, 1'b0);
    endtask : sc_fallback

    task automatic sc_source;
        @(posedge mclk);
        cfg_src_ip <= SRC;
        cw(TPM_CFG_TUNNEL, 2'h2, 3'h0, 32'he000_0003, 16'h1388, 2'h3, 1'b1, 16'h0009, 1'b1);
        pk(32'he000_0003, SRC + 1, IN, 16'h0fa0, 3'h1, 16'h0, 1'b0);
        pk(32'he000_0003, SRC, IN, 16'h0fa0, 3'h4, 16'h0009, 1'b0);
        chk(tun_igmp[5:4], 2'h3);
    endtask : sc_source

    task automatic sc_join;
        logic seen;
        seen = 1'b0;
        @(posedge mclk);
        cfg_src_ip <= SRC + 5;
        cw(TPM_CFG_BACKUP, 2'h1, 3'h0, 32'h0, 16'h0, 2'h0, 1'b0, 16'h0, 1'b0);
        @(posedge mclk);
        primary_lost <= 4'h2;
        for (int i = 0; i < 12 && !seen; i++) begin
            @(posedge mclk);
            #1;
            seen = join_valid;
        end
        if (!seen) begin
            num_errors++;
            test_done();
        end
        chk({join_tun, join_igmp}, 4'h7);
        chk(join_src_ip, SRC + 5);
        seen = 1'b0;
        @(posedge mclk);
        primary_lost <= 4'h6;
        repeat (8) begin
            @(posedge mclk);
            #1;
            seen = seen | join_valid;
        end
        chk(seen, 1'b0);
    endtask : sc_join

    // Duplicate key keeps lowest entry; clear drops the tunnel
    task automatic sc_clear;
        cw(TPM_CFG_ENTRY, 2'h0, 3'h6, IN, 16'h0fa0, 2'h0, 1'b0, 16'h0033, 1'b0);
        pk(32'he000_0001, SRC, IN, 16'h0fa0, 3'h4, 16'h0011, 1'b1);
        cw(TPM_CFG_CLEAR, 2'h0, 3'h0, 32'h0, 16'h0, 2'h0, 1'b0, 16'h0, 1'b0);
        pk(32'he000_0001, SRC, IN, 16'h0fa0, 3'h1, 16'h0, 1'b0);
        chk(tun_igmp[1:0], 2'h0);
    endtask : sc_clear

    ////////////////////////////////////////////////////////////////////////
    // Reset, then the scenarios
    initial begin
        num_errors = 0;
        tests_run = 0;
        {rst_n, cfg_wr, cfg_src_en, cfg_dflt_en, cfg_tun, cfg_igmp, cfg_ent} = '0;
        {cfg_port, cfg_plp, cfg_ip, cfg_src_ip, primary_lost} = '0;
        cfg_kind = TPM_CFG_CLEAR;
        cfg_enable = 1'b1;
        repeat (8) @(posedge mclk);
        chk({route_valid, sec_valid, drop_valid, join_valid, cfg_err, route_plp}, 0);
        rst_n <= 1'b1;
        sc_match();
        sc_fallback();
        sc_source();
        sc_join();
        sc_clear();
        test_done();
    end
endmodule : tpm_mapper_bench

`default_nettype wire
